/* sim_pkg.sv */
// Shared constants and types for the decode, reset-cause and watchdog block
package sim_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int RESET_OUTPUT_NS = 128;
   localparam int RESET_OUTPUT_CYCLES = (RESET_OUTPUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WDOG_CNT_W = 25;

   // ==========================================================
   // Module base register fields
   localparam int BA_HI = 31;
   localparam int BA_LO = 12;
   localparam int WP_BIT = 8;
   localparam int AM_BIT = 6;
   localparam int CI_BIT = 5;
   localparam int SC_BIT = 4;
   localparam int SD_BIT = 3;
   localparam int UC_BIT = 2;
   localparam int UD_BIT = 1;
   localparam int V_BIT = 0;

   // ==========================================================
   // Local register word and its byte lanes
   localparam logic [11:0] SIM_REG_OFFSET = 12'h000;
   localparam int RSR_LANE = 3;
   localparam int PCR_LANE = 2;
   localparam int SVC_LANE = 1;
   localparam int VEC_LANE = 0;

   // Reset-cause status fields and values
   localparam int EXT_RST_BIT = 7;
   localparam int WDOG_RST_BIT = 5;
   localparam logic [7:0] RSR_AFTER_EXT = 8'h80;
   localparam logic [7:0] RSR_AFTER_WDOG = 8'h20;

   // Protection control fields
   localparam int EN_BIT = 7;
   localparam int RI_BIT = 6;
   localparam int PRE_BIT = 5;
   localparam int TIM_HI = 4;
   localparam int TIM_LO = 3;
   localparam int TAE_BIT = 2;
   localparam int TAV_BIT = 1;
   localparam logic [7:0] PCR_RESET = 8'h00;
   localparam logic [7:0] PCR_WMASK = 8'hfc;

   // Service keys
   localparam logic [7:0] KEY_ARM = 8'h55;
   localparam logic [7:0] KEY_SVC = 8'haa;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      SP_USER_DATA,
      SP_USER_CODE,
      SP_SUPER_DATA,
      SP_SUPER_CODE
   } space_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
      space_t space;
      logic cpu_space;
      logic iack;
      logic alt_master;
   } bus_req_t;

   typedef enum logic [1:0] {
      WD_RUN,
      WD_WAIT,
      WD_HUNG
   } wd_state_t;

endpackage

/* sim_decode_reset_watchdog.sv */
// Base-address decode, reset-cause status and software watchdog
// How it works
// - Base register bits 31..12 place a 4-Kbyte register window.
// - With valid set, compare base with upper 20 address bits.
// - Write-protect bit 8 makes the local register word read only; other window writes still flag a peripheral hit.
// - Alternate masters ignore space masks while bit 6 is clear.
// - CPU-space cycles decode if bit 5 clear, else external; acknowledge cycles ignore bit 5, claimed while interrupt pending.
// - Bits 4..1 mask supervisor code/data, then user code/data.
// - Masked-space accesses miss internally and go to the external bus.
// - Bit 0 is valid; clear means no window decode, though acknowledge cycles are still claimed.
// - System reset clears valid; other base bits stay uninitialised.
// - External reset sets the external-reset flag, bit 7.
// - External reset initialises all block registers but base bits 31..1, and resets the core.
// - Watchdog-timeout reset sets the watchdog-reset flag, bit 5.
// - Only the flag of the latest reset cause stays set.
// - Watchdog counts only when enabled, times out unless serviced.
// - Timeout raises interrupt or drives reset output low, per select.
// - Timeout with reset-select clear raises the watchdog interrupt.
// - Watchdog acknowledge gets a supplied vector, not autovectored.
// - No acknowledge after another period: pulse transfer ack, set flag.
// - Timeout with reset selected asserts internal reset, sets flag.
// - Service restarts countdown only after 0x55 then 0xAA; each timeout also restarts it.
// - Anything may occur between the two keys without aborting.
// - Countdown compared continuously with prescale/timing period.
// - Protection control writes ignored while interrupt pending.
`timescale 1ns/1ps
module sim_decode_reset_watchdog #(
   parameter int BASE_SHIFT = 9,
   parameter int PRE_SHIFT = 9,
   parameter logic [7:0] WDOG_VECTOR = 8'h40
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire sim_pkg::bus_req_t bus_req,
   input wire logic base_wr,
   input wire logic [31:0] base_wdata,
   output logic [31:0] base_rdata_q,
   output logic bus_ack_q,
   output logic [31:0] bus_rdata_q,
   output logic periph_hit_q,
   output logic ext_access_q,
   output logic wdog_irq_q,
   output logic wdog_ta_q,
   output logic reset_output_n_q,
   output logic core_reset_q
);
   import sim_pkg::*;

   // ==========================================================
   // Declarations
   logic [31:0] base_q;
   logic [7:0] rsr_q;
   logic [7:0] pcr_q;
   logic armed_q;
   logic [WDOG_CNT_W-1:0] cnt_q;
   logic [WDOG_CNT_W-1:0] limit;
   logic [4:0] shift;
   wd_state_t state_q;
   logic soft_rst_q;
   logic [4:0] reset_output_cnt_q;
   logic any_rst;
   logic space_masked;
   logic in_window;
   logic cpu_blocked;
   logic hit;
   logic local_hit;
   logic wr_ok;
   logic pcr_wr;
   logic svc_wr;
   logic [7:0] svc_byte;
   logic iack_hit;
   logic timeout;
   logic service;

   assign any_rst = sys_rst | soft_rst_q;

   // ==========================================================
   // Address decode
   always_comb begin
      space_marker: begin
         space_masked = 1'b0;
         if (!(bus_req.alt_master && !base_q[AM_BIT])) begin
            case (bus_req.space)
               SP_SUPER_CODE: space_masked = base_q[SC_BIT];
               SP_SUPER_DATA: space_masked = base_q[SD_BIT];
               SP_USER_CODE: space_masked = base_q[UC_BIT];
               default: space_masked = base_q[UD_BIT];
            endcase
         end
      end
   end

   assign in_window = base_q[V_BIT]
      && bus_req.addr[BA_HI:BA_LO] == base_q[BA_HI:BA_LO];
   assign cpu_blocked = bus_req.cpu_space && base_q[CI_BIT];
   assign hit = bus_req.valid && !bus_req.iack && in_window
      && !space_masked && !cpu_blocked;
   assign local_hit = hit
      && bus_req.addr[BA_LO-1:2] == SIM_REG_OFFSET[BA_LO-1:2];
   assign wr_ok = local_hit && bus_req.write && !base_q[WP_BIT];
   assign pcr_wr = wr_ok && bus_req.be[PCR_LANE] && !wdog_irq_q;
   assign svc_wr = wr_ok && bus_req.be[SVC_LANE];
   assign svc_byte = bus_req.wdata[SVC_LANE*8 +: 8];
   // Acknowledge cycle only claimed while our request stands
   assign iack_hit = bus_req.valid && bus_req.iack && wdog_irq_q;

   // ==========================================================
   // Base register: only valid is reset, the rest is left as found
   always_ff @(posedge clk) begin
      if (any_rst) begin
         base_q[V_BIT] <= 1'b0;
      end else if (clk_en && base_wr) begin
         base_q[V_BIT] <= base_wdata[V_BIT];
      end
      // Reserved bits 11..9 and 7 are stored as zero
      if (clk_en && base_wr) begin
         base_q[31:1] <= base_wdata[31:1] & 31'h7ffff8bf;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         base_rdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         base_rdata_q <= base_q;
      end
   end

   // ==========================================================
   // Reset cause and reset sequencing
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rsr_q <= RSR_AFTER_EXT;
      end else if (clk_en && soft_rst_q) begin
         rsr_q <= RSR_AFTER_WDOG;
      end
   end

   // Output low for a fixed stretch so external parts see a clean pulse
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reset_output_cnt_q <= 5'd0;
         reset_output_n_q <= 1'b1;
         core_reset_q <= 1'b1;
      end else if (clk_en) begin
         core_reset_q <= soft_rst_q;
         if (soft_rst_q) begin
            reset_output_cnt_q <= 5'(RESET_OUTPUT_CYCLES - 1);
            reset_output_n_q <= 1'b0;
         end else if (reset_output_cnt_q != 5'd0) begin
            reset_output_cnt_q <= reset_output_cnt_q - 5'd1;
         end else begin
            reset_output_n_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Protection control
   always_ff @(posedge clk) begin
      if (any_rst) begin
         pcr_q <= PCR_RESET;
      end else if (clk_en) begin
         if (pcr_wr) begin
            pcr_q[7:2] <= bus_req.wdata[PCR_LANE*8+2 +: 6];
         end
         // Hardware set beats a write-one clear in the same cycle
         if (timeout && state_q == WD_WAIT && pcr_q[TAE_BIT]) begin
            pcr_q[TAV_BIT] <= 1'b1;
         end else if (pcr_wr && bus_req.wdata[PCR_LANE*8+TAV_BIT]) begin
            pcr_q[TAV_BIT] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Service key sequence
   assign service = svc_wr && armed_q && svc_byte == KEY_SVC;

   always_ff @(posedge clk) begin
      if (any_rst) begin
         armed_q <= 1'b0;
      end else if (clk_en && svc_wr) begin
         if (svc_byte == KEY_ARM) begin
            armed_q <= 1'b1;
         end else if (svc_byte == KEY_SVC) begin
            armed_q <= 1'b0;
         end
         // Other values leave arming untouched
      end
   end

   // ==========================================================
   // Countdown
   assign shift = 5'(BASE_SHIFT) + {2'b00, pcr_q[TIM_HI:TIM_LO], 1'b0}
      + (pcr_q[PRE_BIT] ? 5'(PRE_SHIFT) : 5'd0);
   assign limit = {{(WDOG_CNT_W-1){1'b0}}, 1'b1} << shift;
   assign timeout = pcr_q[EN_BIT]
      && cnt_q == limit - {{(WDOG_CNT_W-1){1'b0}}, 1'b1};

   always_ff @(posedge clk) begin
      if (any_rst) begin
         cnt_q <= '0;
      end else if (clk_en) begin
         if (service || timeout) begin
            cnt_q <= '0;
         end else if (pcr_q[EN_BIT]) begin
            cnt_q <= cnt_q + {{(WDOG_CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ==========================================================
   // Timeout handling
   always_ff @(posedge clk) begin
      if (any_rst) begin
         state_q <= WD_RUN;
         wdog_irq_q <= 1'b0;
         wdog_ta_q <= 1'b0;
         soft_rst_q <= 1'b0;
      end else if (clk_en) begin
         wdog_ta_q <= 1'b0;
         case (state_q)
            WD_RUN: begin
               if (timeout && pcr_q[RI_BIT]) begin
                  soft_rst_q <= 1'b1;
               end else if (timeout) begin
                  wdog_irq_q <= 1'b1;
                  state_q <= WD_WAIT;
               end
            end
            WD_WAIT: begin
               if (iack_hit) begin
                  wdog_irq_q <= 1'b0;
                  state_q <= WD_RUN;
               end else if (timeout && pcr_q[TAE_BIT]) begin
                  wdog_ta_q <= 1'b1;
                  state_q <= WD_HUNG;
               end
            end
            default: begin
               if (iack_hit) begin
                  wdog_irq_q <= 1'b0;
                  state_q <= WD_RUN;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Bus answer, one cycle after the request
   always_ff @(posedge clk) begin
      if (any_rst) begin
         bus_ack_q <= 1'b0;
         bus_rdata_q <= 32'h0000_0000;
         periph_hit_q <= 1'b0;
         ext_access_q <= 1'b0;
      end else if (clk_en) begin
         bus_ack_q <= local_hit || iack_hit;
         periph_hit_q <= hit && !local_hit;
         ext_access_q <= bus_req.valid && !hit && !iack_hit;
         if (iack_hit) begin
            bus_rdata_q <= {24'h00_0000, WDOG_VECTOR};
         end else if (local_hit && !bus_req.write) begin
            bus_rdata_q <= {rsr_q, pcr_q, 8'h00, 8'h00};
         end else begin
            bus_rdata_q <= 32'h0000_0000;
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   chk_ext_flag_reset: assert property (
      $past(sys_rst) |-> rsr_q == RSR_AFTER_EXT)
      else $error("external reset flag not set after reset");
   chk_one_cause_flag: assert property (
      $onehot(rsr_q[EXT_RST_BIT] ^ rsr_q[WDOG_RST_BIT])
      && rsr_q[EXT_RST_BIT] != rsr_q[WDOG_RST_BIT])
      else $error("reset cause flags not exclusive");
   chk_wdog_reset_seq: assert property (
      clk_en && state_q == WD_RUN && timeout && pcr_q[RI_BIT]
      ##1 clk_en |=> rsr_q == RSR_AFTER_WDOG && !reset_output_n_q
      && pcr_q == PCR_RESET)
      else $error("watchdog reset did not take effect");
   chk_irq_on_timeout: assert property (
      clk_en && state_q == WD_RUN && timeout && !pcr_q[RI_BIT]
      |=> wdog_irq_q && state_q == WD_WAIT)
      else $error("timeout did not raise interrupt");
   chk_pcr_locked: assert property (
      wdog_irq_q && clk_en && !soft_rst_q
      |=> pcr_q[7:2] == $past(pcr_q[7:2]))
      else $error("protection control changed while pending");
   chk_no_count_off: assert property (
      !pcr_q[EN_BIT] && !service && !soft_rst_q |=> cnt_q == $past(cnt_q))
      else $error("counter moved while disabled");
   chk_service_reload: assert property (
      clk_en && service && !soft_rst_q |=> cnt_q == '0 && !armed_q)
      else $error("service did not reload countdown");
   chk_arm_only: assert property (
      clk_en && svc_wr && svc_byte == KEY_ARM && !armed_q && !timeout
      && pcr_q[EN_BIT] && !soft_rst_q |=> armed_q && cnt_q != '0)
      else $error("arm key reloaded or failed to arm");
   chk_ta_flag: assert property (
      wdog_ta_q |-> pcr_q[TAV_BIT] && state_q == WD_HUNG)
      else $error("transfer ack without status flag");
   chk_write_protect: assert property (
      clk_en && local_hit && bus_req.write && base_q[WP_BIT] && !wdog_irq_q
      && !soft_rst_q && !timeout |=> pcr_q == $past(pcr_q))
      else $error("write landed in protected window");
   chk_invalid_base: assert property (
      clk_en && bus_req.valid && !bus_req.iack && !base_q[V_BIT]
      && !soft_rst_q |=> ext_access_q && !periph_hit_q && !bus_ack_q)
      else $error("decode hit while base invalid");
   chk_iack_vector: assert property (
      clk_en && iack_hit && !soft_rst_q
      |=> bus_ack_q && bus_rdata_q[7:0] == WDOG_VECTOR && !wdog_irq_q)
      else $error("watchdog acknowledge without vector");
   chk_freeze_count: assert property (
      !clk_en && !soft_rst_q |=> cnt_q == $past(cnt_q))
      else $error("counter moved while clock enable low");
   chk_periph_hit: assert property (
      clk_en && hit && !local_hit && !soft_rst_q
      |=> periph_hit_q && !bus_ack_q && !ext_access_q)
      else $error("window hit not flagged as peripheral");

   cov_irq_path: cover property (state_q == WD_WAIT ##[1:1000] iack_hit);
   cov_ta_path: cover property (wdog_ta_q);
   cov_wdog_reset: cover property (soft_rst_q ##1 !reset_output_n_q);
   cov_service: cover property (service);
   cov_freeze: cover property (!clk_en && pcr_q[EN_BIT]);

endmodule

/* bus_master_model.sv */
// Core or alternate master issuing single register accesses
`timescale 1ns/1ps
module bus_master_model (
   input wire logic clk,
   input wire logic bus_ack_q,
   input wire logic [31:0] bus_rdata_q,
   input wire logic ext_access_q,
   output sim_pkg::bus_req_t bus_req
);
   import sim_pkg::*;
   initial bus_req = '0;
   // One request per call, one cycle of valid
   // Released address and write data show inverted values so stale data cannot pass
   task automatic issue(input logic wr, input logic [31:0] addr,
      input logic [3:0] be, input logic [31:0] wdata, input space_t sp,
      input logic cpu, input logic ia, input logic alt,
      output logic ack, output logic [31:0] rd, output logic ext);
      @(negedge clk);
      bus_req <= '{1'b1, wr, addr, be, wdata, sp, cpu, ia, alt};
      @(negedge clk);
      ack = bus_ack_q;
      rd = bus_rdata_q;
      ext = ext_access_q;
      bus_req.valid <= 1'b0;
      bus_req.addr <= ~addr;
      bus_req.wdata <= ~wdata;
   endtask
endmodule

/* test_sim_decode_reset_watchdog.sv */
// Self-checking bench for decode, reset cause and watchdog
`timescale 1ns/1ps
module test_sim_decode_reset_watchdog;
   import sim_pkg::*;
   `define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin \
      err_total++; $display("ERROR %0t: got %h exp %h", $time, g, e); \
      end end
   localparam logic [31:0] BASE = 32'h1000_0000;
   typedef struct {
      logic [8:0] cfg;
      space_t sp;
      logic cpu;
      logic alt;
      logic [31:0] addr;
      logic hit;
   } row_t;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic base_wr = 1'b0;
   logic [31:0] base_wdata = 32'h0000_0000;
   bus_req_t bus_req;
   logic [31:0] base_rdata_q, bus_rdata_q, rd;
   logic bus_ack_q, periph_hit_q, ext_access_q, wdog_irq_q, wdog_ta_q;
   logic reset_output_n_q, core_reset_q, ack, ext;
   int err_total = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;
   row_t rows [11] = '{
      '{9'h001, SP_SUPER_DATA, 1'b0, 1'b0, BASE, 1'b1},
      '{9'h001, SP_SUPER_DATA, 1'b0, 1'b0, BASE + 32'h1000, 1'b0},
      '{9'h000, SP_SUPER_DATA, 1'b0, 1'b0, BASE, 1'b0},
      '{9'h011, SP_SUPER_CODE, 1'b0, 1'b0, BASE, 1'b0},
      '{9'h009, SP_SUPER_DATA, 1'b0, 1'b0, BASE, 1'b0},
      '{9'h005, SP_USER_CODE, 1'b0, 1'b0, BASE, 1'b0},
      '{9'h003, SP_USER_DATA, 1'b0, 1'b0, BASE, 1'b0},
      '{9'h003, SP_USER_DATA, 1'b0, 1'b1, BASE, 1'b1},
      '{9'h043, SP_USER_DATA, 1'b0, 1'b1, BASE, 1'b0},
      '{9'h001, SP_SUPER_DATA, 1'b1, 1'b0, BASE, 1'b1},
      '{9'h021, SP_SUPER_DATA, 1'b1, 1'b0, BASE, 1'b0}};

   always #4 clk = ~clk;

   bus_master_model BM (.clk(clk), .bus_ack_q(bus_ack_q),
      .bus_rdata_q(bus_rdata_q), .ext_access_q(ext_access_q),
      .bus_req(bus_req));

   sim_decode_reset_watchdog #(.BASE_SHIFT(2), .PRE_SHIFT(1)) DUT (
      .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus_req(bus_req),
      .base_wr(base_wr), .base_wdata(base_wdata),
      .base_rdata_q(base_rdata_q), .bus_ack_q(bus_ack_q),
      .bus_rdata_q(bus_rdata_q), .periph_hit_q(periph_hit_q),
      .ext_access_q(ext_access_q), .wdog_irq_q(wdog_irq_q),
      .wdog_ta_q(wdog_ta_q), .reset_output_n_q(reset_output_n_q),
      .core_reset_q(core_reset_q));

   // =====================================
   // Access helpers
   task automatic set_base(input logic [31:0] v);
      @(negedge clk);
      base_wr <= 1'b1;
      base_wdata <= v;
      @(negedge clk);
      base_wr <= 1'b0;
      base_wdata <= ~v;
   endtask
   task automatic rd_at(input logic [31:0] a, input space_t sp,
      input logic cpu, input logic ia, input logic alt);
      BM.issue(1'b0, a, 4'hf, 32'h0, sp, cpu, ia, alt, ack, rd, ext);
   endtask
   task automatic wr_lane(input int lane, input logic [7:0] v);
      BM.issue(1'b1, BASE, 4'(1 << lane), {4{v}}, SP_SUPER_DATA, 1'b0,
         1'b0, 1'b0, ack, rd, ext);
   endtask
   task automatic rd_word;
      rd_at(BASE, SP_SUPER_DATA, 1'b0, 1'b0, 1'b0);
   endtask
   task automatic iack;
      rd_at(32'hffff_fff0, SP_SUPER_DATA, 1'b1, 1'b1, 1'b0);
   endtask
   // Key order kept by software; reload needs both
   task automatic service;
      wr_lane(SVC_LANE, KEY_ARM);
      wr_lane(SVC_LANE, KEY_SVC);
   endtask
   task automatic end_test(input string s);
      $display("Test %s done", s);
   endtask
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Roughly 2000 cycles expected
   always @(posedge clk) begin
      cycles++;
      if (cycles == 12000) begin
         err_total++;
         $display("ERROR %0t: run hung", $time);
         complete_run();
      end
   end

   // =====================================
   // Main sequence
   initial begin
      repeat (6) @(negedge clk);
      sys_rst <= 1'b0;
      rd_word();
      `CHECK(ext, 1'b1)
      set_base(BASE | 32'h1);
      rd_word();
      `CHECK(rd[31:16], {RSR_AFTER_EXT, PCR_RESET})
      `CHECK(base_rdata_q, BASE | 32'h1)
      `CHECK(reset_output_n_q, 1'b1)
      end_test("reset");
      for (int i = 0; i < 11; i++) begin
         set_base(BASE | 32'(rows[i].cfg));
         rd_at(rows[i].addr, rows[i].sp, rows[i].cpu, 1'b0, rows[i].alt);
         `CHECK(ack, rows[i].hit)
         `CHECK(ext, !rows[i].hit)
      end
      rd_at(BASE + 32'h4, SP_SUPER_DATA, 1'b0, 1'b0, 1'b0);
      `CHECK(periph_hit_q, 1'b1)
      `CHECK(ack, 1'b0)
      `CHECK(ext, 1'b0)
      end_test("decode");
      set_base(BASE | 32'hf81);
      wr_lane(PCR_LANE, 8'h18);
      `CHECK(base_rdata_q, BASE | 32'h101)
      set_base(BASE | 32'h1);
      rd_word();
      `CHECK(rd[23:16], 8'h00)
      wr_lane(PCR_LANE, 8'h18);
      rd_word();
      `CHECK(rd[23:16], 8'h18)
      end_test("protect");
      // Period 16 with transfer acknowledge enabled
      wr_lane(PCR_LANE, 8'h8c);
      for (n = 0; n < 40 && wdog_irq_q !== 1'b1; n++) @(negedge clk);
      `CHECK(wdog_irq_q, 1'b1)
      `CHECK(core_reset_q, 1'b0)
      for (n = 0; n < 40 && wdog_ta_q !== 1'b1; n++) @(negedge clk);
      `CHECK(wdog_ta_q, 1'b1)
      wr_lane(PCR_LANE, 8'h00);
      rd_word();
      `CHECK(rd[23:16], 8'h8e)
      iack();
      `CHECK(ack, 1'b1)
      `CHECK(rd[7:0], 8'h40)
      `CHECK(wdog_irq_q, 1'b0)
      wr_lane(PCR_LANE, 8'h02);
      repeat (40) @(negedge clk);
      rd_word();
      `CHECK(rd[23:16], 8'h00)
      `CHECK(wdog_irq_q, 1'b0)
      end_test("timeout");
      // Period 512; disable, service, set period, enable
      service();
      wr_lane(PCR_LANE, 8'hb8);
      for (int i = 0; i < 8; i++) begin
         wr_lane(SVC_LANE, KEY_ARM);
         rd_word();
         wr_lane(SVC_LANE, 8'h12);
         wr_lane(SVC_LANE, KEY_SVC);
         repeat (150) @(negedge clk);
         `CHECK(wdog_irq_q, 1'b0)
      end
      wr_lane(SVC_LANE, KEY_ARM);
      for (n = 0; n < 600 && wdog_irq_q !== 1'b1; n++) @(negedge clk);
      `CHECK(wdog_irq_q, 1'b1)
      `CHECK(n > 300, 1'b1)
      iack();
      wr_lane(PCR_LANE, 8'h00);
      end_test("service");
      service();
      wr_lane(PCR_LANE, 8'hc0);
      for (n = 0; n < 20 && core_reset_q !== 1'b1; n++) @(negedge clk);
      `CHECK(core_reset_q, 1'b1)
      for (n = 0; n < 4 && reset_output_n_q !== 1'b0; n++) @(negedge clk);
      for (n = 0; n < 40 && reset_output_n_q === 1'b0; n++) @(negedge clk);
      `CHECK(n, RESET_OUTPUT_CYCLES)
      rd_word();
      `CHECK(ext, 1'b1)
      set_base(BASE | 32'h1);
      rd_word();
      `CHECK(rd[31:16], {RSR_AFTER_WDOG, PCR_RESET})
      end_test("wdog_reset");
      sys_rst <= 1'b1;
      repeat (2) @(negedge clk);
      `CHECK(core_reset_q, 1'b1)
      sys_rst <= 1'b0;
      set_base(BASE | 32'h1);
      rd_word();
      `CHECK(rd[31:16], {RSR_AFTER_EXT, PCR_RESET})
      end_test("ext_reset");
      // Low clock enable must hold the countdown
      service();
      wr_lane(PCR_LANE, 8'h88);
      @(negedge clk);
      clk_en <= 1'b0;
      repeat (40) @(negedge clk);
      `CHECK(wdog_irq_q, 1'b0)
      clk_en <= 1'b1;
      for (n = 0; n < 40 && wdog_irq_q !== 1'b1; n++) @(negedge clk);
      `CHECK(wdog_irq_q, 1'b1)
      `CHECK(n > 10, 1'b1)
      end_test("freeze");
      complete_run();
   end
endmodule
